// ---- fsr_fan_model.sv ----
// four-wire fan model: pwm duty in, tachometer pulses out
`timescale 1ns/10ps
module fsr_fan_model (
    input wire logic clk,
    input wire logic pwm,
    input wire logic stop,
    output logic tach
);
    int win;
    int hi;
    int duty;
    int cnt;
    initial begin
        win = 0;
        hi = 0;
        duty = 0;
        cnt = 0;
        tach = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    // duty seen over one full 400-clock pwm period, so phase does not matter
    // speed is linear in duty; tach toggles four times per revolution
    always @(posedge clk) begin
        win <= (win == 399) ? 0 : win + 1;
        hi <= (win == 399) ? 0 : hi + int'(pwm);
        if (win == 399) begin
            duty <= hi + int'(pwm);
        end
        // a stopped rotor leaves the open-collector line at its pull-up
        if (stop) begin
            tach <= 1'b1;
            cnt <= 0;
        end else if (cnt >= 150000000 / (40000 + duty * 60)) begin
            tach <= !tach;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : fsr_fan_model

// ---- fsr_map.svh ----
// constants of the closed-loop fan speed regulator
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH
`define FSR_NUM_FANS 2
`define FSR_CLK_HZ 10000000
`define FSR_PWM_HZ 25000
`define FSR_PWM_CYC (`FSR_CLK_HZ / `FSR_PWM_HZ)
`define FSR_PCT_FULL 100
`define FSR_DUTY_PER_PCT (`FSR_PWM_CYC / `FSR_PCT_FULL)
`define FSR_STALL_MS 500
`define FSR_STALL_CYC (`FSR_STALL_MS * (`FSR_CLK_HZ / 1000))
`define FSR_RPM_NUM (60 * `FSR_CLK_HZ)
`define FSR_FINE_STEP 9'h001
`define FSR_COARSE_STEP 9'h008
`define FSR_COARSE_RPM 500
`define FSR_DUTY_RST 9'h000
`define FSR_RPM_RST 16'h0000
`define FSR_RPM_SAT 16'hFFFF
`endif

// ---- fsr_pkg.sv ----
// types shared by the fan speed regulator files
package fsr_pkg;
    typedef logic [15:0] fsr_rpm_t;
    typedef logic [8:0] fsr_duty_t;
    typedef logic [6:0] fsr_pct_t;
    typedef enum logic {TS_SEEK = 1'b0, TS_TIME = 1'b1} fsr_tach_st_t;
endpackage : fsr_pkg

// ---- fsr_regulator.sv ----
// closed-loop speed regulator for two pwm fans with stall and speed alerts
// Contract
// - hardware mode keeps correcting duty without software
// - new target loads estimated duty, then refines
// - estimate interpolates two duty/rpm points per fan
// - stalled tachometer raises per-fan stall condition
// - unreachable target raises speed failure condition
// - all conditions share one alert output
// - stall and speed alerts separately enabled
// - alert high from the first enabled condition's onset until none remains or a status is read
// - alert source shows stall and/or speed
// - per-fan stall and speed status readable
// - reading either status clears the alert
// - pulse when both fans measured anew
`timescale 1ns/10ps
`include "fsr_map.svh"
module fsr_regulator #(
    parameter int STALL_CYC = `FSR_STALL_CYC
) (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic HARDWARE_REGULATION_MODE,
    input wire logic STALL_ALERT_EN,
    input wire logic SPEED_ALERT_EN,
    input wire fsr_pkg::fsr_rpm_t TOLERANCE_RPM,
    input wire fsr_pkg::fsr_rpm_t DESIRED_RPM_1,
    input wire fsr_pkg::fsr_rpm_t DESIRED_RPM_2,
    input wire fsr_pkg::fsr_pct_t DUTY_A_PCT_1,
    input wire fsr_pkg::fsr_rpm_t RPM_A_1,
    input wire fsr_pkg::fsr_pct_t DUTY_B_PCT_1,
    input wire fsr_pkg::fsr_rpm_t RPM_B_1,
    input wire fsr_pkg::fsr_pct_t DUTY_A_PCT_2,
    input wire fsr_pkg::fsr_rpm_t RPM_A_2,
    input wire fsr_pkg::fsr_pct_t DUTY_B_PCT_2,
    input wire fsr_pkg::fsr_rpm_t RPM_B_2,
    input wire logic TACH_1,
    input wire logic TACH_2,
    input wire logic RD_STALL_STATUS,
    input wire logic RD_SPEED_STATUS,
    output logic FAN_PWM_1,
    output logic FAN_PWM_2,
    output fsr_pkg::fsr_rpm_t ACTUAL_RPM_1,
    output fsr_pkg::fsr_rpm_t ACTUAL_RPM_2,
    output fsr_pkg::fsr_duty_t DUTY_1,
    output fsr_pkg::fsr_duty_t DUTY_2,
    output logic MEAS_DONE,
    output logic ALERT,
    output logic [1:0] ALERT_SOURCE,
    output logic [1:0] STALL_STATUS,
    output logic [1:0] SPEED_STATUS
);
    import fsr_pkg::*;

    localparam int NF = `FSR_NUM_FANS;

    fsr_rpm_t des_w [NF];
    fsr_rpm_t ra_w [NF];
    fsr_rpm_t rb_w [NF];
    fsr_pct_t pa_w [NF];
    fsr_pct_t pb_w [NF];
    fsr_rpm_t act_w [NF];
    fsr_duty_t duty_reg [NF];
    logic [NF-1:0] tach_w, done_w, stall_w, fail_reg, pwm_reg, fresh_reg;
    logic [8:0] pwm_cnt_reg;
    logic eoc_reg;

    // host supplies only desired rpm as a target
    assign des_w[0] = DESIRED_RPM_1;
    assign des_w[1] = DESIRED_RPM_2;
    assign ra_w[0] = RPM_A_1;
    assign ra_w[1] = RPM_A_2;
    assign rb_w[0] = RPM_B_1;
    assign rb_w[1] = RPM_B_2;
    assign pa_w[0] = DUTY_A_PCT_1;
    assign pa_w[1] = DUTY_A_PCT_2;
    assign pb_w[0] = DUTY_B_PCT_1;
    assign pb_w[1] = DUTY_B_PCT_2;
    assign tach_w = {TACH_2, TACH_1};

    ////////////////////////////////////////////////////////////////////////
    // pwm time base shared by both fans
    wire pwm_wrap = pwm_cnt_reg == 9'(`FSR_PWM_CYC - 1);

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            pwm_cnt_reg <= 9'h000;
        end else begin
            pwm_cnt_reg <= pwm_wrap ? 9'h000 : pwm_cnt_reg + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-fan measurement, estimate and correction
    genvar i;
    generate
        for (i = 0; i < NF; i++) begin : g_fan
            fsr_rpm_t seen_reg;
            fsr_tach #(.STALL_CYC(STALL_CYC)) u_tach (
                .clk(CLOCK),
                .rst_n(RESET_N),
                .tach_pin(tach_w[i]),
                .rpm(act_w[i]),
                .done(done_w[i]),
                .stalled(stall_w[i])
            );

            // linear interpolation through the two configured points
            wire signed [31:0] span_rpm = 32'(ra_w[i] > rb_w[i] ?
                -$signed(32'(ra_w[i] - rb_w[i])) : $signed(32'(rb_w[i] - ra_w[i])));
            wire signed [31:0] span_duty = ($signed(32'(pb_w[i])) -
                $signed(32'(pa_w[i]))) * `FSR_DUTY_PER_PCT;
            wire signed [31:0] offs = $signed(32'(des_w[i])) -
                $signed(32'(ra_w[i]));
            wire signed [31:0] base = $signed(32'(pa_w[i])) * `FSR_DUTY_PER_PCT;
            // equal rpm points give no slope: fall back to point a
            wire signed [31:0] est = base + ((span_rpm == 0) ? 32'sd0 :
                offs * span_duty / span_rpm);
            wire fsr_duty_t est_duty = (est < 0) ? 9'h000 :
                (est > `FSR_PWM_CYC) ? 9'(`FSR_PWM_CYC) : est[8:0];

            wire signed [31:0] err = $signed(32'(des_w[i])) -
                $signed(32'(act_w[i]));
            wire [31:0] abs_err = (err < 0) ? 32'(-err) : 32'(err);
            wire in_band = abs_err <= 32'(TOLERANCE_RPM);
            wire fsr_duty_t step = (abs_err > `FSR_COARSE_RPM) ?
                `FSR_COARSE_STEP : `FSR_FINE_STEP;
            wire at_max = duty_reg[i] == 9'(`FSR_PWM_CYC);
            wire at_min = duty_reg[i] == 9'h000;
            wire fsr_duty_t up = (duty_reg[i] + step > 9'(`FSR_PWM_CYC)) ?
                9'(`FSR_PWM_CYC) : duty_reg[i] + step;
            wire fsr_duty_t dn = (duty_reg[i] < step) ? 9'h000 :
                duty_reg[i] - step;
            // pinned at a duty limit yet still outside the band
            wire fail_cond = !in_band &&
                ((err > 0 && at_max) || (err < 0 && at_min));
            wire new_target = des_w[i] != seen_reg;

            always_ff @(posedge CLOCK or negedge RESET_N) begin
                if (!RESET_N) begin
                    seen_reg <= `FSR_RPM_RST;
                    duty_reg[i] <= `FSR_DUTY_RST;
                    fail_reg[i] <= 1'b0;
                end else if (new_target) begin
                    seen_reg <= des_w[i];
                    duty_reg[i] <= est_duty;
                    fail_reg[i] <= 1'b0;
                end else if (eoc_reg && HARDWARE_REGULATION_MODE) begin
                    if (!in_band) begin
                        duty_reg[i] <= (err > 0) ? up : dn;
                    end
                    fail_reg[i] <= fail_cond;
                end
            end

            always_ff @(posedge CLOCK or negedge RESET_N) begin
                if (!RESET_N) begin
                    pwm_reg[i] <= 1'b0;
                end else begin
                    pwm_reg[i] <= pwm_cnt_reg < duty_reg[i];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // measurement-complete pulse once both fans report anew
    wire all_fresh = &fresh_reg;

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            fresh_reg <= '0;
            eoc_reg <= 1'b0;
        end else begin
            // a result landing in the clearing cycle is kept
            fresh_reg <= done_w | (fresh_reg & ~{NF{all_fresh}});
            eoc_reg <= all_fresh;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alert logic
    logic [1:0] stall_stat_reg, speed_stat_reg, src_reg;
    logic alert_reg, cond_prev_reg;
    wire [1:0] stall_ev = stall_w & {NF{STALL_ALERT_EN}};
    wire [1:0] speed_ev = fail_reg & {NF{SPEED_ALERT_EN}};
    wire any_cond = |{stall_ev, speed_ev};
    wire onset = any_cond && !cond_prev_reg;
    wire rd_any = RD_STALL_STATUS || RD_SPEED_STATUS;

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            stall_stat_reg <= 2'h0;
            speed_stat_reg <= 2'h0;
            src_reg <= 2'h0;
            alert_reg <= 1'b0;
            cond_prev_reg <= 1'b0;
        end else begin
            // set wins over the clearing read
            stall_stat_reg <= stall_ev |
                (stall_stat_reg & ~{NF{RD_STALL_STATUS}});
            speed_stat_reg <= speed_ev |
                (speed_stat_reg & ~{NF{RD_SPEED_STATUS}});
            src_reg <= {|speed_stat_reg, |stall_stat_reg};
            cond_prev_reg <= any_cond;
            // a read drops the pin until a fresh onset, even if it lingers
            alert_reg <= onset ||
                (alert_reg && any_cond && !rd_any);
        end
    end

    assign FAN_PWM_1 = pwm_reg[0];
    assign FAN_PWM_2 = pwm_reg[1];
    assign ACTUAL_RPM_1 = act_w[0];
    assign ACTUAL_RPM_2 = act_w[1];
    assign DUTY_1 = duty_reg[0];
    assign DUTY_2 = duty_reg[1];
    assign MEAS_DONE = eoc_reg;
    assign ALERT = alert_reg;
    assign ALERT_SOURCE = src_reg;
    assign STALL_STATUS = stall_stat_reg;
    assign SPEED_STATUS = speed_stat_reg;
endmodule : fsr_regulator

// ---- fsr_regulator_sva.sv ----
// assertion checker of the fan speed regulator ports
`timescale 1ns/10ps
`include "fsr_map.svh"
module fsr_regulator_sva #(
    parameter int STALL_CYC = `FSR_STALL_CYC
) (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic STALL_ALERT_EN,
    input wire logic SPEED_ALERT_EN,
    input wire fsr_pkg::fsr_rpm_t DESIRED_RPM_1,
    input wire fsr_pkg::fsr_rpm_t DESIRED_RPM_2,
    input wire fsr_pkg::fsr_pct_t DUTY_A_PCT_1,
    input wire fsr_pkg::fsr_rpm_t RPM_A_1,
    input wire fsr_pkg::fsr_pct_t DUTY_B_PCT_1,
    input wire fsr_pkg::fsr_rpm_t RPM_B_1,
    input wire logic RD_STALL_STATUS,
    input wire logic RD_SPEED_STATUS,
    input wire fsr_pkg::fsr_duty_t DUTY_1,
    input wire fsr_pkg::fsr_duty_t DUTY_2,
    input wire logic MEAS_DONE,
    input wire logic ALERT,
    input wire logic [1:0] ALERT_SOURCE,
    input wire logic [1:0] STALL_STATUS,
    input wire logic [1:0] SPEED_STATUS
);
    import fsr_pkg::*;
    int est_1;
    // interpolated duty in 1/400 units, clamped to the pwm range
    function automatic int est(int pa, int ra, int pb, int rb, int d);
        int e;
        e = (ra == rb) ? 4 * pa : 4 * pa + (d - ra) * 4 * (pb - pa) / (rb - ra);
        return (e < 0) ? 0 : ((e > 400) ? 400 : e);
    endfunction : est
    assign est_1 = est(DUTY_A_PCT_1, RPM_A_1, DUTY_B_PCT_1, RPM_B_1,
        DESIRED_RPM_1);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESET_N);
    ////////////////////////////////////////////////////////////////////////
    chk_meas_pulse: assert property (
        MEAS_DONE |=> !MEAS_DONE)
        else $error("done pulse longer than one cycle");
    chk_target_estimate: assert property (
        $changed(DESIRED_RPM_1) |=> int'(DUTY_1) == $past(est_1))
        else $error("duty not loaded with estimate");
    chk_duty_hold: assert property (
        $past(RESET_N) && !MEAS_DONE
        && $stable({DESIRED_RPM_1, DESIRED_RPM_2})
        |=> $stable({DUTY_1, DUTY_2}))
        else $error("duty moved outside a correction tick");
    chk_alert_cause: assert property (
        ALERT |-> |{STALL_STATUS, SPEED_STATUS})
        else $error("alert without any status");
    chk_source_map: assert property (
        ALERT_SOURCE == {|$past(SPEED_STATUS), |$past(STALL_STATUS)})
        else $error("alert source disagrees with statuses");
    chk_stall_gate: assert property (
        $rose(|STALL_STATUS) |-> $past(STALL_ALERT_EN))
        else $error("stall status set while disabled");
    chk_speed_gate: assert property (
        $rose(|SPEED_STATUS) |-> $past(SPEED_ALERT_EN))
        else $error("speed status set while disabled");
    // a bit newly set in the next cycle may be a fresh onset
    chk_read_clear: assert property (
        (RD_STALL_STATUS || RD_SPEED_STATUS) && ALERT
        ##1 !(|(STALL_STATUS & ~$past(STALL_STATUS))
        || |(SPEED_STATUS & ~$past(SPEED_STATUS))) |-> !ALERT)
        else $error("alert stayed high after a status read");
    cov_meas: cover property (MEAS_DONE);
    cov_stall: cover property (ALERT && STALL_STATUS[1]);
    cov_speed: cover property (ALERT && SPEED_STATUS[0]);
endmodule : fsr_regulator_sva
bind fsr_regulator fsr_regulator_sva #(.STALL_CYC(STALL_CYC))
    i_fsr_regulator_sva (
    .CLOCK(CLOCK),
    .RESET_N(RESET_N),
    .STALL_ALERT_EN(STALL_ALERT_EN),
    .SPEED_ALERT_EN(SPEED_ALERT_EN),
    .DESIRED_RPM_1(DESIRED_RPM_1),
    .DESIRED_RPM_2(DESIRED_RPM_2),
    .DUTY_A_PCT_1(DUTY_A_PCT_1),
    .RPM_A_1(RPM_A_1),
    .DUTY_B_PCT_1(DUTY_B_PCT_1),
    .RPM_B_1(RPM_B_1),
    .RD_STALL_STATUS(RD_STALL_STATUS),
    .RD_SPEED_STATUS(RD_SPEED_STATUS),
    .DUTY_1(DUTY_1),
    .DUTY_2(DUTY_2),
    .MEAS_DONE(MEAS_DONE),
    .ALERT(ALERT),
    .ALERT_SOURCE(ALERT_SOURCE),
    .STALL_STATUS(STALL_STATUS),
    .SPEED_STATUS(SPEED_STATUS)
);

// ---- fsr_regulator_test.sv ----
// self-checking bench of the fan speed regulator
`timescale 1ns/10ps
module fsr_regulator_test;
    import fsr_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, mode = 1'b1, stall_en = 1'b1;
    logic speed_en = 1'b0, rd_stall = 1'b0, rd_speed = 1'b0, stop_2 = 1'b0;
    logic tach_1, tach_2, pwm_1, pwm_2, meas_done, alert;
    logic [1:0] alert_src, stall_st, speed_st, seen;
    logic [15:0] hi_cnt;
    fsr_rpm_t tol = 16'h0064, des_1 = 16'h0000, des_2 = 16'h0000;
    fsr_rpm_t ra = 16'h9C40, rb = 16'hFA00, rpm_1, rpm_2;
    fsr_pct_t pa = 7'h00, pb = 7'h64;
    fsr_duty_t duty_1, duty_2;
    int mismatches = 0, n_compared = 0, cycles = 0;
    always #50 clk = ~clk;
    // short stall time keeps the run brief; still above two tach periods
    fsr_regulator #(.STALL_CYC(20000)) i_fsr_regulator (.CLOCK(clk),
        .RESET_N(rst_n), .HARDWARE_REGULATION_MODE(mode),
        .STALL_ALERT_EN(stall_en), .SPEED_ALERT_EN(speed_en),
        .TOLERANCE_RPM(tol), .DESIRED_RPM_1(des_1), .DESIRED_RPM_2(des_2),
        .DUTY_A_PCT_1(pa), .RPM_A_1(ra), .DUTY_B_PCT_1(pb), .RPM_B_1(rb),
        .DUTY_A_PCT_2(pa), .RPM_A_2(ra), .DUTY_B_PCT_2(pb), .RPM_B_2(rb),
        .TACH_1(tach_1), .TACH_2(tach_2), .RD_STALL_STATUS(rd_stall),
        .RD_SPEED_STATUS(rd_speed), .FAN_PWM_1(pwm_1), .FAN_PWM_2(pwm_2),
        .ACTUAL_RPM_1(rpm_1), .ACTUAL_RPM_2(rpm_2), .DUTY_1(duty_1),
        .DUTY_2(duty_2), .MEAS_DONE(meas_done), .ALERT(alert),
        .ALERT_SOURCE(alert_src), .STALL_STATUS(stall_st),
        .SPEED_STATUS(speed_st));
    fsr_fan_model i_fsr_fan_model_1 (.clk(clk), .pwm(pwm_1), .stop(1'b0),
        .tach(tach_1));
    fsr_fan_model i_fsr_fan_model_2 (.clk(clk), .pwm(pwm_2), .stop(stop_2),
        .tach(tach_2));
    ////////////////////////////////////////////////////////////////////////
    task check(input logic [15:0] seen_v, input logic [15:0] exp_v);
        n_compared++;
        if (seen_v !== exp_v) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen_v,
                exp_v);
        end
    endtask : check
    task give_verdict;
        $display("compared %0d, mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    task wait_for(input bit want_alert);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (((want_alert ? alert : meas_done) !== 1'b1) && n < 40000);
        if (n >= 40000) begin
            mismatches++;
            give_verdict();
        end
    endtask : wait_for
    task set_target(input bit fan_2, input fsr_rpm_t r);
        if (fan_2) begin
            des_2 = r;
        end else begin
            des_1 = r;
        end
        @(negedge clk);
    endtask : set_target
    task read_status(input bit speed, output logic [1:0] v);
        v = speed ? speed_st : stall_st;
        rd_speed = speed;
        rd_stall = !speed;
        @(negedge clk);
        rd_speed = 1'b0;
        rd_stall = 1'b0;
    endtask : read_status
    // speed the fan model settles at, as one whole revolution measures it
    function automatic fsr_rpm_t rpm_of(input int d);
        return 16'(600000000 / (4 * (150000000 / (40000 + d * 60) + 1)));
    endfunction : rpm_of
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            mismatches++;
            give_verdict();
        end
    end
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check(16'(alert), 16'h0000);
        $display("test reset done");
        set_target(1'b0, 16'hCB20);
        check(16'(duty_1), 16'h00C8);
        set_target(1'b1, 16'hE290);
        check(16'(duty_2), 16'h012C);
        set_target(1'b0, 16'hFDE8);
        check(16'(duty_1), 16'h0190);
        $display("test estimate done");
        repeat (2) wait_for(1'b0);
        check(16'(alert), 16'h0000);
        check(16'(speed_st), 16'h0000);
        speed_en = 1'b1;
        wait_for(1'b1);
        check(16'(speed_st), 16'h0001);
        check(16'(duty_2), 16'h012C);
        check(rpm_1, rpm_of(400));
        check(rpm_2, rpm_of(300));
        @(negedge clk);
        check(16'(alert_src), 16'h0002);
        read_status(1'b1, seen);
        check(16'(seen), 16'h0001);
        check(16'(alert), 16'h0000);
        // one whole pwm period holds exactly duty high clocks
        hi_cnt = 16'h0000;
        repeat (400) begin
            @(negedge clk);
            hi_cnt += 16'(pwm_2);
        end
        check(hi_cnt, 16'h012C);
        $display("test speed failure done");
        // a narrow band turns the small residual error into one fine step
        tol = 16'h000A;
        wait_for(1'b0);
        @(negedge clk);
        check(16'(duty_2), 16'h012D);
        mode = 1'b0;
        wait_for(1'b0);
        @(negedge clk);
        check(16'(duty_2), 16'h012D);
        mode = 1'b1;
        tol = 16'h0064;
        $display("test regulation done");
        set_target(1'b0, 16'hCB20);
        check(16'(duty_1), 16'h00C8);
        stop_2 = 1'b1;
        wait_for(1'b1);
        check(16'(stall_st), 16'h0002);
        check(rpm_2, 16'h0000);
        @(negedge clk);
        // speed status stays sticky until read, so both sources show
        check(16'(alert_src), 16'h0003);
        read_status(1'b0, seen);
        check(16'(seen), 16'h0002);
        repeat (3) @(negedge clk);
        check(16'(alert), 16'h0000);
        $display("test stall done");
        give_verdict();
    end
endmodule : fsr_regulator_test

// ---- fsr_tach.sv ----
// tachometer speed meter with stall timeout for one fan
`timescale 1ns/10ps
`include "fsr_map.svh"
module fsr_tach #(
    parameter int STALL_CYC = `FSR_STALL_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tach_pin,
    output fsr_pkg::fsr_rpm_t rpm,
    output logic done,
    output logic stalled
);
    import fsr_pkg::*;

    logic s1_reg, s2_reg, s3_reg, lvl_reg;
    logic [23:0] cnt_reg;
    logic half_reg;
    fsr_tach_st_t st_reg;
    fsr_rpm_t rpm_reg;
    logic done_reg, stall_reg;

    ////////////////////////////////////////////////////////////////////////
    // three-stage synchroniser; a level counts once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // tach idles high at its pull-up; a low reset would fake a rise
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            lvl_reg <= 1'b1;
        end else begin
            s1_reg <= tach_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                lvl_reg <= s3_reg;
            end
        end
    end

    wire rise = (s2_reg == s3_reg) && s3_reg && !lvl_reg;
    wire timeout = cnt_reg >= 24'(STALL_CYC - 1);
    // two tach pulses per revolution: one period spans three rising edges
    wire [31:0] period_w = 32'(cnt_reg) + 32'h0000_0001;
    wire [31:0] quot_w = 32'(`FSR_RPM_NUM) / period_w;
    wire [15:0] rpm_w = (quot_w > 32'h0000_FFFF) ? `FSR_RPM_SAT : quot_w[15:0];

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 24'h000000;
            half_reg <= 1'b0;
            st_reg <= TS_SEEK;
            rpm_reg <= `FSR_RPM_RST;
            done_reg <= 1'b0;
            stall_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (rise && st_reg == TS_SEEK) begin
                st_reg <= TS_TIME;
                cnt_reg <= 24'h000000;
                half_reg <= 1'b0;
            end else if (rise && !half_reg) begin
                half_reg <= 1'b1;
                cnt_reg <= cnt_reg + 24'h000001;
            end else if (rise) begin
                rpm_reg <= rpm_w;
                done_reg <= 1'b1;
                stall_reg <= 1'b0;
                cnt_reg <= 24'h000000;
                half_reg <= 1'b0;
            end else if (timeout) begin
                rpm_reg <= `FSR_RPM_RST;
                done_reg <= 1'b1;
                stall_reg <= 1'b1;
                cnt_reg <= 24'h000000;
                st_reg <= TS_SEEK;
            end else begin
                cnt_reg <= cnt_reg + 24'h000001;
            end
        end
    end

    assign rpm = rpm_reg;
    assign done = done_reg;
    assign stalled = stall_reg;
endmodule : fsr_tach
